// ### src/erd_mem_if.sv
// interface: word command path between engine and memory master
`timescale 1ns/100ps
`default_nettype none
interface erd_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  modport ctl (output req, output we, output addr, output wdata, input rdata, input done);
  modport port (input req, input we, input addr, input wdata, output rdata, output done);
endinterface : erd_mem_if
`default_nettype wire

// ### src/erd_mem_master.sv
// module: single word memory master behind the descriptor engine
`timescale 1ns/100ps
`default_nettype none
module erd_mem_master
  import erd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  erd_mem_if.port cmd,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i
);
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
  } erd_mm_t;
  erd_mm_t q, d;

  // ----------------------------------------
  // request held until memory acknowledges
  // ----------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (q.req && mem_ack_i) begin
      d.req = 1'b0;
      d.done = 1'b1;
      d.rdata = mem_rdata_i;
    end else if (!q.req && cmd.req) begin
      d.req = 1'b1;
      d.we = cmd.we;
      d.addr = cmd.addr;
      d.wdata = cmd.wdata;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mem_req_o = q.req;
  assign mem_we_o = q.we;
  assign mem_addr_o = q.addr;
  assign mem_wdata_o = q.wdata;
  assign cmd.rdata = q.rdata;
  assign cmd.done = q.done;
endmodule : erd_mem_master
`default_nettype wire

// ### src/erd_pkg.sv
// package: constants and types for the receive descriptor dma
package erd_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [31:0] ERD_OFS_OPM = 32'h0000_0000;
  localparam logic [31:0] ERD_OFS_STS = 32'h0000_0004;
  localparam logic [31:0] ERD_OFS_POLL = 32'h0000_0008;
  localparam logic [31:0] ERD_OFS_BASE = 32'h0000_000C;
  localparam logic [31:0] ERD_OFS_CUR = 32'h0000_0010;
  localparam logic [31:0] ERD_OFS_MISS = 32'h0000_0014;
  localparam logic [31:0] ERD_OFS_MAC = 32'h0000_0018;
  localparam logic [31:0] ERD_OFS_THR = 32'h0000_001C;
  // ----------------------------------------
  // register field positions
  // ----------------------------------------
  localparam int ERD_OPM_RUN = 1;
  localparam int ERD_OPM_KEEP = 24;
  localparam int ERD_STS_RI = 6;
  localparam int ERD_STS_RBU = 7;
  localparam int ERD_MAC_STRIP_A = 7;
  localparam int ERD_MAC_STRIP_B = 25;
  localparam logic [11:0] ERD_THR_RST = 12'h010;
  // ----------------------------------------
  // descriptor layout: four words, word 0 fields
  // ----------------------------------------
  localparam logic [31:0] ERD_W0_OFS = 32'h0000_0000;
  localparam logic [31:0] ERD_W1_OFS = 32'h0000_0004;
  localparam logic [31:0] ERD_W2_OFS = 32'h0000_0008;
  localparam logic [31:0] ERD_W3_OFS = 32'h0000_000C;
  localparam int ERD_D_OWN = 31;
  localparam int ERD_D_DAF = 30;
  localparam int ERD_D_ERRSUM = 15;
  localparam int ERD_D_TRUNC = 14;
  localparam int ERD_D_FIRST = 9;
  localparam int ERD_D_LAST = 8;
  localparam logic [13:0] ERD_CRC_BYTES = 14'h0004;
  localparam logic [14:0] ERD_WORD_BYTES = 15'h0004;
  // ----------------------------------------
  // receive engine states, gray along the usual path
  // ----------------------------------------
  typedef enum logic [3:0] {
    ERD_IDLE = 4'h0, ERD_RD0 = 4'h1, ERD_RD1 = 4'h3, ERD_RD2 = 4'h2,
    ERD_RD3 = 4'h6, ERD_WAIT = 4'h7, ERD_XFER = 4'h5, ERD_NEXT = 4'h4,
    ERD_CLOSE = 4'hC, ERD_SUSP = 4'hD, ERD_REREAD = 4'hF, ERD_DROP = 4'hE
  } erd_state_t;
endpackage : erd_pkg

// ### src/erd_rx_dma.sv
// module: ethernet receive descriptor dma engine with wishbone registers
//
// Overview of operation
// R01 - setting the run control starts a descriptor fetch at once
// R02 - a full buffer before frame end makes the engine fetch another descriptor
// R03 - frame end with the descriptor still open leads to the next fetch
// R04 - a new frame during suspend retries descriptor acquisition
// R05 - a software poll demand triggers a descriptor acquisition attempt
// R06 - transfer starts only when the fifo threshold level is reached; the code also starts once a whole frame is in the fifo
// R07 - the descriptor getting a frame's first segment has the first flag
// R08 - descriptors go back to the cpu with ownership cleared
// R09 - a frame in a single buffer gets both first and last flags
// R10 - fetch next, mark last, write status, close, then raise receive status
// R11 - cpu owned descriptor sets buffer unavailable then suspends
// R12 - the descriptor pointer is kept across suspend and reused
// R13 - in suspend each new frame rereads the current descriptor
// R14 - still cpu owned: drop head frame and count it missed
// R15 - reread and drop repeat for every frame waiting in the fifo
// R16 - with flush disabled, no drop; buffer unavailable and back to suspend
// R17 - a descriptor is four consecutive 32 bit words
// R18 - word 0 bit 31 is ownership, one means dma owned
// R19 - word 0 bit 30 reports destination filter failure
// R20 - word 0 bits 29:16 hold the frame byte count
// R21 - without the last flag the length holds bytes moved so far
// R22 - mac control bits 7 and 25 decide whether crc counts in length
// R23 - error summary bit 15 is the or of the error flags
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module erd_rx_dma
  import erd_pkg::*;
#(
  parameter int LVL_W = 12,
  parameter int MISS_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // system memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // receive fifo
  input wire logic [LVL_W-1:0] fifo_level_i,
  input wire logic [7:0] fifo_frames_i,
  input wire logic fifo_new_frame_i,
  input wire logic fifo_valid_i,
  input wire logic [31:0] fifo_data_i,
  input wire logic fifo_last_i,
  input wire logic [2:0] fifo_bytes_i,
  input wire logic [5:0] rx_stat_i,
  input wire logic rx_da_fail_i,
  output logic fifo_pop_o,
  output logic fifo_flush_o
);
  typedef struct packed {
    erd_state_t st;
    logic run;
    logic keep;
    logic strip_a;
    logic strip_b;
    logic [LVL_W-1:0] thr;
    logic [31:0] base;
    logic [31:0] cur;
    logic [31:0] nxt;
    logic [31:0] baddr;
    logic [12:0] bsz;
    logic [13:0] seg;
    logic [13:0] frm;
    logic in_frame;
    logic first;
    logic last;
    logic trunc;
    logic eof;
    logic [2:0] nb;
    logic nxt_own;
    logic more;
    logic poll_only;
    logic [5:0] stat;
    logic daf;
    logic ri;
    logic rbu;
    logic pend;
    logic poll;
    logic [MISS_W-1:0] missed;
    logic iss;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdat;
    logic pop;
    logic flush;
  } erd_top_t;
  erd_top_t q, d;

  erd_mem_if mif ();

  erd_mem_master u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd(mif.port),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte lane merge for wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic wb_hit;
  logic full;
  logic [13:0] len;
  logic [31:0] w0;
  logic [31:0] sts_rd;
  logic [31:0] thr_new;

  // a frame ending now reports its length less crc when stripping applies
  always_comb begin
    wb_hit = wb_cyc_i && wb_stb_i && !q.ack;
    full = ({1'b0, q.seg} + ERD_WORD_BYTES) > {2'b00, q.bsz}; // see R02
    len = q.frm; // see R21
    if (q.last && (q.strip_a || q.strip_b) && (q.frm >= ERD_CRC_BYTES)) begin
      len = q.frm - ERD_CRC_BYTES; // see R22
    end
    w0 = '0;
    w0[ERD_D_OWN] = 1'b0; // see R08
    w0[ERD_D_DAF] = q.daf; // see R19
    w0[29:16] = len; // see R20
    w0[ERD_D_TRUNC] = q.trunc;
    w0[ERD_D_FIRST] = q.first; // see R07
    w0[ERD_D_LAST] = q.last; // see R09
    w0[1] = q.stat[0];
    w0[3] = q.stat[1];
    w0[4] = q.stat[2];
    w0[6] = q.stat[3];
    w0[7] = q.stat[4];
    w0[11] = q.stat[5];
    w0[ERD_D_ERRSUM] = w0[1] | w0[3] | w0[4] | w0[6] | w0[7] | w0[11] | w0[14]; // see R23
    sts_rd = '0;
    sts_rd[ERD_STS_RI] = q.ri;
    sts_rd[ERD_STS_RBU] = q.rbu;
    sts_rd[20:17] = q.st;
    thr_new = merge({{(32-LVL_W){1'b0}}, q.thr}, wb_dat_i, wb_sel_i);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.pop = 1'b0;
    d.flush = 1'b0;
    d.req = 1'b0;
    // register access: one wait cycle, unmapped reads give zero
    if (wb_hit) begin
      d.ack = 1'b1;
      d.rdat = '0;
      case (wb_adr_i)
        ERD_OFS_OPM: begin
          d.rdat[ERD_OPM_RUN] = q.run;
          d.rdat[ERD_OPM_KEEP] = q.keep;
        end
        ERD_OFS_STS: d.rdat = sts_rd;
        ERD_OFS_BASE: d.rdat = q.base;
        ERD_OFS_CUR: d.rdat = q.cur;
        ERD_OFS_MISS: d.rdat[MISS_W-1:0] = q.missed;
        ERD_OFS_MAC: begin
          d.rdat[ERD_MAC_STRIP_A] = q.strip_a;
          d.rdat[ERD_MAC_STRIP_B] = q.strip_b;
        end
        ERD_OFS_THR: d.rdat[LVL_W-1:0] = q.thr;
        default: d.rdat = '0;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i)
          ERD_OFS_OPM: begin
            d.run = wb_sel_i[0] ? wb_dat_i[ERD_OPM_RUN] : q.run;
            d.keep = wb_sel_i[3] ? wb_dat_i[ERD_OPM_KEEP] : q.keep;
          end
          // write one to clear; a same-cycle hardware set below still wins
          ERD_OFS_STS: begin
            if (wb_sel_i[0] && wb_dat_i[ERD_STS_RI]) begin
              d.ri = 1'b0;
            end
            if (wb_sel_i[0] && wb_dat_i[ERD_STS_RBU]) begin
              d.rbu = 1'b0;
            end
          end
          ERD_OFS_POLL: d.poll = 1'b1; // see R05
          // the list pointer only restarts from base on a base write
          ERD_OFS_BASE: begin
            d.base = merge(q.base, wb_dat_i, wb_sel_i);
            d.cur = d.base;
          end
          ERD_OFS_MAC: begin
            d.strip_a = wb_sel_i[0] ? wb_dat_i[ERD_MAC_STRIP_A] : q.strip_a;
            d.strip_b = wb_sel_i[3] ? wb_dat_i[ERD_MAC_STRIP_B] : q.strip_b;
          end
          ERD_OFS_THR: d.thr = thr_new[LVL_W-1:0];
          default: d.run = q.run;
        endcase
      end
    end
    // frame arrivals are remembered until the suspend logic consumes them or the idle state clears them
    if (fifo_new_frame_i) begin
      d.pend = 1'b1;
    end
    // engine
    case (q.st)
      ERD_IDLE: begin
        d.pend = 1'b0;
        d.poll = 1'b0;
        if (q.run) begin
          d.st = ERD_RD0; // see R01
        end
      end
      ERD_RD0, ERD_RD1, ERD_RD2, ERD_RD3, ERD_REREAD: begin
        if (!q.iss) begin
          d.req = 1'b1; // see R17
          d.we = 1'b0;
          d.iss = 1'b1;
          case (q.st)
            ERD_RD1: d.addr = q.cur + ERD_W1_OFS;
            ERD_RD2: d.addr = q.cur + ERD_W2_OFS;
            ERD_RD3: d.addr = q.cur + ERD_W3_OFS;
            default: d.addr = q.cur + ERD_W0_OFS;
          endcase
        end else if (mif.done) begin
          d.iss = 1'b0;
          case (q.st)
            ERD_RD0: begin
              if (mif.rdata[ERD_D_OWN]) begin
                d.st = ERD_RD1; // see R18
              end else begin
                d.rbu = 1'b1; // see R11
                d.st = ERD_SUSP;
              end
            end
            ERD_RD1: begin
              d.bsz = mif.rdata[12:0];
              d.st = ERD_RD2;
            end
            ERD_RD2: begin
              d.baddr = mif.rdata;
              d.st = ERD_RD3;
            end
            ERD_RD3: begin
              d.nxt = mif.rdata;
              d.seg = '0;
              d.st = q.in_frame ? ERD_XFER : ERD_WAIT;
            end
            default: begin
              if (mif.rdata[ERD_D_OWN]) begin
                d.st = ERD_RD1; // see R13
              end else if (q.poll_only || (fifo_frames_i == 8'h00)) begin
                // nothing waiting in the fifo, so nothing to drop or count
                d.rbu = 1'b1;
                d.st = ERD_SUSP;
              end else if (q.keep) begin
                d.rbu = 1'b1; // see R16
                d.st = ERD_SUSP;
              end else begin
                d.flush = 1'b1; // see R14
                d.rbu = 1'b1;
                d.missed = q.missed + 1'b1;
                d.more = fifo_frames_i > 8'h01; // see R15
                d.st = ERD_DROP;
              end
            end
          endcase
        end
      end
      ERD_WAIT: begin
        if (!q.run) begin
          d.st = ERD_IDLE;
        end else if ((fifo_level_i >= q.thr) || (fifo_frames_i != 8'h00)) begin
          d.in_frame = 1'b1; // see R06
          d.first = 1'b1; // see R07
          d.frm = '0;
          d.st = ERD_XFER;
        end
      end
      ERD_XFER: begin
        if (!q.iss && full) begin
          d.last = 1'b0;
          d.st = ERD_NEXT; // see R02
        end else if (!q.iss && fifo_valid_i) begin
          d.req = 1'b1;
          d.we = 1'b1;
          d.addr = q.baddr + {18'h00000, q.seg};
          d.wdata = fifo_data_i;
          d.pop = 1'b1;
          d.iss = 1'b1;
          d.eof = fifo_last_i;
          d.nb = fifo_bytes_i;
          if (fifo_last_i) begin
            d.stat = rx_stat_i;
            d.daf = rx_da_fail_i;
          end
        end else if (q.iss && mif.done) begin
          d.iss = 1'b0;
          d.seg = q.seg + {11'h000, q.nb};
          d.frm = q.frm + {11'h000, q.nb};
          if (q.eof) begin
            d.last = 1'b1;
            d.in_frame = 1'b0;
            d.st = ERD_NEXT; // see R03
          end
        end
      end
      // look at the next descriptor before closing the current one
      ERD_NEXT: begin
        if (!q.iss) begin
          d.req = 1'b1; // see R10
          d.we = 1'b0;
          d.addr = q.nxt + ERD_W0_OFS;
          d.iss = 1'b1;
        end else if (mif.done) begin
          d.iss = 1'b0;
          d.nxt_own = mif.rdata[ERD_D_OWN];
          if (!mif.rdata[ERD_D_OWN] && !q.last) begin
            d.trunc = 1'b1;
            d.last = 1'b1;
            d.in_frame = 1'b0;
            d.flush = !q.keep;
          end
          d.st = ERD_CLOSE;
        end
      end
      ERD_CLOSE: begin
        if (!q.iss) begin
          d.req = 1'b1;
          d.we = 1'b1;
          d.addr = q.cur + ERD_W0_OFS;
          d.wdata = w0; // see R08
          d.iss = 1'b1;
        end else if (mif.done) begin
          d.iss = 1'b0;
          // set wins over a same-cycle clear, without undoing a clear otherwise
          if (q.last) begin
            d.ri = 1'b1; // see R10
          end
          d.first = 1'b0;
          d.last = 1'b0;
          d.trunc = 1'b0;
          d.stat = '0;
          d.daf = 1'b0;
          d.cur = q.nxt;
          if (q.nxt_own) begin
            d.st = ERD_RD1;
          end else begin
            d.rbu = 1'b1; // see R11
            d.st = ERD_SUSP;
          end
        end
      end
      // pointer is left alone here so the same descriptor is reread
      ERD_SUSP: begin // see R12
        if (!q.run) begin
          d.st = ERD_IDLE;
        end else if (q.pend || q.poll) begin
          d.poll_only = !q.pend && (fifo_frames_i == 8'h00);
          d.pend = fifo_new_frame_i;
          d.poll = 1'b0;
          d.st = ERD_REREAD; // see R04
        end
      end
      ERD_DROP: begin
        d.st = q.more ? ERD_REREAD : ERD_SUSP; // see R15
        d.poll_only = 1'b0;
      end
      default: d.st = ERD_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.thr <= ERD_THR_RST[LVL_W-1:0];
    end else begin
      q <= d;
    end
  end

  assign mif.req = q.req;
  assign mif.we = q.we;
  assign mif.addr = q.addr;
  assign mif.wdata = q.wdata;
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign fifo_pop_o = q.pop;
  assign fifo_flush_o = q.flush;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_run_fetch: assert property (@(posedge clk_i) disable iff (rst_i) // see R01
    (q.st == ERD_IDLE && q.run) |=> (q.st == ERD_RD0 && !q.iss) ##1 q.req)
    else $error("run did not start a descriptor fetch");
  chk_full_next: assert property (@(posedge clk_i) disable iff (rst_i) // see R02
    (q.st == ERD_XFER && !q.iss && full) |=> q.st == ERD_NEXT)
    else $error("full buffer did not lead to next descriptor");
  chk_thr_start: assert property (@(posedge clk_i) disable iff (rst_i) // see R06
    (q.st == ERD_WAIT ##1 q.st == ERD_XFER) |->
      $past(fifo_level_i >= q.thr || fifo_frames_i != 8'h00))
    else $error("transfer began below threshold");
  chk_close_own: assert property (@(posedge clk_i) disable iff (rst_i) // see R08
    (q.st == ERD_CLOSE && q.req) |-> (q.we && !q.wdata[ERD_D_OWN] && q.addr == q.cur))
    else $error("close write keeps ownership");
  chk_ri_last: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    (q.st == ERD_CLOSE && q.iss && mif.done && q.last) |=> q.ri)
    else $error("receive status not raised after close");
  chk_rbu_susp: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    (q.st != ERD_SUSP ##1 q.st == ERD_SUSP) |-> q.rbu || $past(wb_hit && wb_we_i))
    else $error("suspend entered without buffer unavailable");
  chk_keep_ptr: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    (q.st == ERD_SUSP && !(wb_hit && wb_we_i)) |=> q.cur == $past(q.cur))
    else $error("pointer moved during suspend");
  chk_miss_cnt: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    (q.st == ERD_DROP) |-> (q.flush && q.missed == $past(q.missed) + 1'b1))
    else $error("drop without flush and count");
  chk_noflush_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    (q.st == ERD_REREAD && q.iss && mif.done && !mif.rdata[ERD_D_OWN] && q.keep)
      |=> (q.st == ERD_SUSP && !q.flush && q.rbu))
    else $error("flush disabled but frame dropped");
  chk_err_sum: assert property (@(posedge clk_i) disable iff (rst_i) // see R23
    (q.st == ERD_CLOSE && q.req) |-> q.wdata[ERD_D_ERRSUM] == ((|q.stat) | q.trunc))
    else $error("error summary mismatch");
endmodule : erd_rx_dma
`default_nettype wire

// ### verification/erd_mem_model.sv
// memory model: descriptor list and frame buffers answering the engine's word requests
`timescale 1ns/100ps
`default_nettype none
module erd_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  logic [31:0] mem [0:2047];
  logic served_q;
  int wait_q;
  // one answer per held request, after 0..3 idle cycles; read data toggles
  // between answers so a stale sample never looks valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      served_q <= 1'b0;
      wait_q <= 0;
      rdata_o <= 32'hA5A5_5A5A;
    end else if (req_i && !served_q) begin
      if (wait_q == 0) begin
        ack_o <= 1'b1;
        served_q <= 1'b1;
        wait_q <= $urandom_range(3, 0);
        if (we_i) mem[addr_i[12:2]] <= wdata_i;
        else rdata_o <= mem[addr_i[12:2]];
      end else begin
        wait_q <= wait_q - 1;
      end
    end else if (!req_i) begin
      served_q <= 1'b0;
    end
  end
endmodule : erd_mem_model
`default_nettype wire

// ### verification/test_erd_rx_dma.sv
// testbench: receive descriptor engine with a memory model and a fifo driver
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module test_erd_rx_dma;
  import erd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, new_frame = 1'b0, da = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [5:0] stat = 6'h00;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rd, dat_o, m_addr, m_wdata, m_rdata;
  logic ack, m_req, m_we, m_ack, pop, flush;
  logic [31:0] fq [0:511];
  logic [2:0] fb [0:511];
  logic fl [0:511];
  int hd = 0, tl = 0, fpush = 0, fcons = 0, n_fail = 0, checks = 0, nb, st;
  always #25 clk_i = ~clk_i;
  erd_rx_dma dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mem_req_o(m_req), .mem_we_o(m_we), .mem_addr_o(m_addr), .mem_wdata_o(m_wdata),
    .mem_rdata_i(m_rdata), .mem_ack_i(m_ack), .fifo_level_i(12'(tl - hd)),
    .fifo_frames_i(8'(fpush - fcons)), .fifo_new_frame_i(new_frame), .fifo_valid_i(hd != tl),
    .fifo_data_i(fq[hd]), .fifo_last_i(fl[hd]), .fifo_bytes_i(fb[hd]), .rx_stat_i(stat),
    .rx_da_fail_i(da), .fifo_pop_o(pop), .fifo_flush_o(flush));
  erd_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(m_req), .we_i(m_we),
    .addr_i(m_addr), .wdata_i(m_wdata), .rdata_o(m_rdata), .ack_o(m_ack));
  // ---------------------------------------------------------
  // fifo driver
  // ---------------------------------------------------------
  function automatic int frame_end(input int h);
    int k;
    for (k = h; k < tl && !fl[k]; k++) begin end
    return k + 1;
  endfunction : frame_end
  // a pop consumes the head word, a flush drops the rest of the head frame
  always @(posedge clk_i) begin
    if (pop && hd != tl) begin
      hd <= hd + 1;
      if (fl[hd]) fcons <= fcons + 1;
    end else if (flush && hd != tl) begin
      hd <= frame_end(hd);
      fcons <= fcons + 1;
    end
  end
  // whole frame lands at once, so the level jumps past the threshold in one step
  task automatic push(input int n);
    int w;
    w = (n + 3) / 4;
    @(posedge clk_i);
    st = tl;
    stat <= 6'($urandom);
    da <= 1'($urandom);
    for (int i = 0; i < w; i++) begin
      fq[tl + i] = $urandom;
      fl[tl + i] = (i == w - 1);
      fb[tl + i] = (i == w - 1 && n % 4 != 0) ? 3'(n % 4) : 3'h4;
    end
    tl <= tl + w;
    fpush <= fpush + 1;
    new_frame <= 1'b1;
    @(posedge clk_i);
    new_frame <= 1'b0;
  endtask : push
  // ---------------------------------------------------------
  // register access and expectations
  // ---------------------------------------------------------
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= w ? 4'hF : 4'($urandom);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, rd);
    `CHK(nm, e, rd)
  endtask : rdchk
  // bounded poll of a register until the masked value shows up
  task automatic wait_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, rd);
      n++;
    end while ((rd & m) !== v && n < 400);
    `CHK("poll", v, rd & m)
  endtask : wait_reg
  function automatic logic [31:0] exp_w0(input int len, input logic fs, input logic ls);
    logic [31:0] w;
    w = 32'h0;
    w[29:16] = 14'(len);
    w[ERD_D_FIRST] = fs;
    w[ERD_D_LAST] = ls;
    if (ls) begin
      w[ERD_D_DAF] = da;
      {w[11], w[7], w[6], w[4], w[3], w[1]} = stat;
      w[ERD_D_ERRSUM] = |stat;
    end
    return w;
  endfunction : exp_w0
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // watchdog: far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (80000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    nb = $urandom(32'hF3094571);
    for (int i = 0; i < 8; i++) begin
      mem_u.mem[64 + 4 * i] = (i < 5) ? 32'h8000_0000 : 32'h0;
      mem_u.mem[65 + 4 * i] = 32'h0000_0040;
      mem_u.mem[66 + 4 * i] = 32'h0000_1000 + 32'h100 * i;
      mem_u.mem[67 + 4 * i] = 32'h0000_0110 + 32'h10 * i;
    end
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ERD_OFS_STS, 32'h0, "status");
    rdchk(ERD_OFS_MISS, 32'h0, "missed");
    rdchk(ERD_OFS_THR, {20'h0, ERD_THR_RST}, "threshold");
    rdchk(32'h0000_0040, 32'h0, "unmapped");
    $display("test reset done");
    wb(1'b1, ERD_OFS_THR, 32'h0000_0004, rd);
    wb(1'b1, ERD_OFS_BASE, 32'h0000_0100, rd);
    wb(1'b1, ERD_OFS_OPM, 32'h0000_0002, rd);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ERD_OFS_MAC, k == 0 ? 32'h0 : k == 1 ? 32'h80 : 32'h0200_0000, rd);
      nb = (k == 0) ? 16 : $urandom_range(60, 17);
      push(nb);
      wait_reg(ERD_OFS_STS, 32'h40, 32'h40);
      `CHK("desc", exp_w0(k == 0 ? nb : nb - 4, 1'b1, 1'b1), mem_u.mem[64 + 4 * k])
      for (int i = 0; i < (nb + 3) / 4; i++)
        `CHK("buffer", fq[st + i], mem_u.mem[1024 + 64 * k + i])
      wb(1'b1, ERD_OFS_STS, 32'h40, rd);
    end
    $display("test single buffer frames done");
    wb(1'b1, ERD_OFS_MAC, 32'h0, rd);
    push(80);
    wait_reg(ERD_OFS_STS, 32'hC0, 32'hC0);
    `CHK("desc_mid", exp_w0(64, 1'b1, 1'b0), mem_u.mem[76])
    `CHK("desc_end", exp_w0(80, 1'b0, 1'b1), mem_u.mem[80])
    rdchk(ERD_OFS_CUR, 32'h0000_0150, "current");
    wb(1'b1, ERD_OFS_STS, 32'hC0, rd);
    $display("test buffer spill done");
    push(20);
    wait_reg(ERD_OFS_MISS, 32'hFFFF_FFFF, 32'h1);
    push(24);
    push(24);
    wait_reg(ERD_OFS_MISS, 32'hFFFF_FFFF, 32'h3);
    `CHK("fifo_empty", tl, hd)
    wb(1'b1, ERD_OFS_OPM, 32'h0100_0002, rd);
    wb(1'b1, ERD_OFS_STS, 32'h80, rd);
    nb = 28;
    push(nb);
    wait_reg(ERD_OFS_STS, 32'h80, 32'h80);
    rdchk(ERD_OFS_MISS, 32'h3, "missed_kept");
    `CHK("fifo_kept", 1'b1, hd != tl)
    mem_u.mem[84] = 32'h8000_0000;
    wb(1'b1, ERD_OFS_POLL, 32'h1, rd);
    wait_reg(ERD_OFS_STS, 32'h40, 32'h40);
    `CHK("desc_resume", exp_w0(nb, 1'b1, 1'b1), mem_u.mem[84])
    $display("test suspend and resume done");
    // next descriptor cpu owned mid-frame: truncation closes with last and error
    wb(1'b1, ERD_OFS_STS, 32'hC0, rd);
    mem_u.mem[88] = 32'h8000_0000;
    push(80);
    wait_reg(ERD_OFS_STS, 32'h40, 32'h40);
    `CHK("desc_trunc", exp_w0(64, 1'b1, 1'b0) | 32'h0000_C100, mem_u.mem[88])
    $display("test truncation done");
    conclude();
  end
endmodule : test_erd_rx_dma
`default_nettype wire
